// [include/des_drive_enable_sequencer_map.vh]
// Constants for the drive enable sequencer: map, fields, resets, timing.
// Operation
// - Without hardware enable, report axis state 0 and controller code 0x03.
// - Hardware enable but no software enable: axis state 1, code 0x10.
// - Both enables and no error: lift brake, torque on, charge, phases on.
// - Jobs accepted only after brake release delay, default 100 ms.
// - On enable removal, decelerate with maximum motor current.
// - Below standstill speed of 10 rpm during ramp-down, drop the brake.
// - Remove torque once the brake engage delay has elapsed.
// - Ready contact stays closed during an error-free ramp-down.
// - Controlled ramp-down applies only while coast on disable is false.
// - Ramp-down is error-free only if standstill precedes the deadline.
// - Bus cycle period of 1, 2 or 4 ms, set by control register bits 5:4.
// - Missed deadline raises stop time error, class B, opens ready.
`ifndef DES_DRIVE_ENABLE_SEQUENCER_MAP_VH
`define DES_DRIVE_ENABLE_SEQUENCER_MAP_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DES_OFS_CTRL      8'h00
`define DES_OFS_STATUS    8'h04
`define DES_OFS_IRQ_STS   8'h08
`define DES_OFS_IRQ_MASK  8'h0C
`define DES_OFS_REL_DLY   8'h10
`define DES_OFS_ENG_DLY   8'h14
`define DES_OFS_DEADLINE  8'h18
`define DES_OFS_STANDSTL  8'h1C
`define DES_OFS_ERR_CLR   8'h20
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define DES_CTRL_SW_EN    0
`define DES_CTRL_COAST_DIS 1
`define DES_CTRL_COAST_ERR 2
`define DES_CTRL_CYC_LO   4
`define DES_CTRL_CYC_HI   5
// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define DES_IRQ_JOBS      0
`define DES_IRQ_BRAKE     1
`define DES_IRQ_TORQ_OFF  2
`define DES_IRQ_STOP_ERR  3
`define DES_IRQ_W         4
// ----------------------------------------------------------------------
// Reported codes
// ----------------------------------------------------------------------
`define DES_AX_NOHW       8'h00
`define DES_AX_WAITSW     8'h01
`define DES_AX_ACTIVE     8'h02
`define DES_AX_STOPPING   8'h03
`define DES_AX_FAULT      8'h04
`define DES_CC_NOHW       8'h03
`define DES_CC_WAITSW     8'h10
`define DES_CC_RELEASE    8'h20
`define DES_CC_RUN        8'h30
`define DES_CC_STOPPING   8'h40
`define DES_CC_FAULT      8'h02
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DES_CLK_PERIOD_NS 50
`define DES_TICK_NS       250000
`define DES_TICK_CYCLES   (`DES_TICK_NS / `DES_CLK_PERIOD_NS)
`define DES_TICK_US       250
`define DES_REL_DLY_MS    100
`define DES_REL_DLY_TICKS 16'h0190
`define DES_ENG_DLY_TICKS 16'h00C8
`define DES_DEADLINE_TICKS 16'h0FA0
`define DES_STANDSTILL_RPM 16'h000A
`define DES_CYC_1MS_TICKS 5'h04
`define DES_CYC_2MS_TICKS 5'h08
`define DES_CYC_4MS_TICKS 5'h10
`endif

// [design/des_sync.v]
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module des_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// [design/des_tick_div.v]
// Divider that turns the system clock into a one-cycle tick enable.
`timescale 1ns/10ps
module des_tick_div #(
	parameter CYCLES = 5000
) (
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Tick
	output wire tick
);
	reg [15:0] cnt_reg;
	reg        tick_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (cnt_reg == CYCLES[15:0] - 16'h0001) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg  <= cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	assign tick = tick_reg;
endmodule

// [design/des_drive_enable_sequencer.v]
// Enable and disable sequencer for one servo drive axis, with APB registers.
`timescale 1ns/10ps
`include "des_drive_enable_sequencer_map.vh"
module des_drive_enable_sequencer #(
	parameter TICK_CYCLES = `DES_TICK_CYCLES
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Machine controller
	input  wire        hw_enable_in,
	output wire [7:0]  axis_state_code,
	output wire [7:0]  controller_state_code,
	output wire        job_accept,
	output wire        bus_cycle_tick,
	output wire        irq,
	// Power stage, brake and ready contact
	input  wire [15:0] measured_speed,
	output wire        brake_relay_on,
	output wire        torque_on,
	output wire        dc_charge_on,
	output wire        phases_connect,
	output wire        max_current_decel,
	output wire        ready_contact
);
	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam [7:0] S_NOHW    = 8'h01;
	localparam [7:0] S_WAITSW  = 8'h02;
	localparam [7:0] S_RELEASE = 8'h04;
	localparam [7:0] S_RUN     = 8'h08;
	localparam [7:0] S_RAMP    = 8'h10;
	localparam [7:0] S_ENGAGE  = 8'h20;
	localparam [7:0] S_COAST   = 8'h40;
	localparam [7:0] S_FAULT   = 8'h80;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	wire                  tick;
	wire                  hw_en;
	wire                  enable_all;
	wire                  standstill;
	wire                  timer_done;
	wire                  wr_access;
	wire                  rd_access;
	wire                  setup;
	reg  [7:0]            state_reg;
	reg  [7:0]            state_next;
	reg  [15:0]           timer_reg;
	reg  [15:0]           timer_next;
	reg                   err_reg;
	reg                   err_next;
	reg                   second_reg;
	reg                   second_next;
	reg  [5:0]            ctrl_reg;
	reg  [15:0]           rel_dly_reg;
	reg  [15:0]           eng_dly_reg;
	reg  [15:0]           deadline_reg;
	reg  [15:0]           standstl_reg;
	reg  [`DES_IRQ_W-1:0] irq_sts_reg;
	reg  [`DES_IRQ_W-1:0] irq_mask_reg;
	reg  [`DES_IRQ_W-1:0] irq_ev;
	reg  [`DES_IRQ_W-1:0] rd_capt_reg;
	reg  [31:0]           prdata_reg;
	reg  [31:0]           rd_value;
	reg                   err_ack;
	reg  [4:0]            cyc_cnt_reg;
	reg                   cyc_tick_reg;
	reg  [7:0]            ax_code_reg;
	reg  [7:0]            cc_code_reg;
	reg  [5:0]            drive_reg;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `DES_OFS_CTRL) || (a == `DES_OFS_STATUS) ||
				(a == `DES_OFS_IRQ_STS) || (a == `DES_OFS_IRQ_MASK) ||
				(a == `DES_OFS_REL_DLY) || (a == `DES_OFS_ENG_DLY) ||
				(a == `DES_OFS_DEADLINE) || (a == `DES_OFS_STANDSTL) ||
				(a == `DES_OFS_ERR_CLR);
		end
	endfunction

	function [4:0] cycle_ticks;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    cycle_ticks = `DES_CYC_1MS_TICKS;
				2'h1:    cycle_ticks = `DES_CYC_2MS_TICKS;
				default: cycle_ticks = `DES_CYC_4MS_TICKS;
			endcase
		end
	endfunction

	des_tick_div #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	des_sync #(
		.WIDTH (1)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (hw_enable_in),
		.sync_out (hw_en)
	);

	assign enable_all = hw_en && ctrl_reg[`DES_CTRL_SW_EN];
	assign standstill = measured_speed < standstl_reg;
	assign timer_done = (timer_reg == 16'h0000);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// A single down-counter serves every wait, because only one wait is
	// ever open at a time; it is reloaded on entry to release, ramp and engage, and on a missed deadline.
	always @* begin
		state_next  = state_reg;
		timer_next  = timer_reg;
		err_next    = err_reg;
		second_next = second_reg;
		irq_ev      = {`DES_IRQ_W{1'b0}};
		if (tick && !timer_done) begin
			timer_next = timer_reg - 16'h0001;
		end
		case (state_reg)
			S_NOHW: begin
				if (hw_en) begin
					state_next = S_WAITSW;
				end
			end
			S_WAITSW: begin
				if (!hw_en) begin
					state_next = S_NOHW;
				end else if (enable_all && !err_reg) begin
					state_next = S_RELEASE;
					timer_next = rel_dly_reg;
				end
			end
			S_RELEASE: begin
				if (!enable_all) begin
					if (ctrl_reg[`DES_CTRL_COAST_DIS]) begin
						state_next = S_COAST;
					end else begin
						state_next  = S_RAMP;
						timer_next  = deadline_reg;
						second_next = 1'b0;
					end
				end else if (timer_done) begin
					state_next = S_RUN;
					irq_ev[`DES_IRQ_JOBS] = 1'b1;
				end
			end
			S_RUN: begin
				if (!enable_all) begin
					if (ctrl_reg[`DES_CTRL_COAST_DIS]) begin
						state_next = S_COAST;
					end else begin
						state_next  = S_RAMP;
						timer_next  = deadline_reg;
						second_next = 1'b0;
					end
				end
			end
			S_RAMP: begin
				if (standstill) begin
					state_next = S_ENGAGE;
					timer_next = eng_dly_reg;
					irq_ev[`DES_IRQ_BRAKE] = 1'b1;
				end else if (timer_done && !second_reg) begin
					err_next    = 1'b1;
					second_next = 1'b1;
					timer_next  = deadline_reg;
					irq_ev[`DES_IRQ_STOP_ERR] = 1'b1;
					if (ctrl_reg[`DES_CTRL_COAST_ERR]) begin
						state_next = S_COAST;
					end
				end else if (timer_done) begin
					state_next = S_ENGAGE;
					timer_next = eng_dly_reg;
					irq_ev[`DES_IRQ_BRAKE] = 1'b1;
				end
			end
			S_ENGAGE: begin
				if (timer_done) begin
					state_next = err_reg ? S_FAULT : S_WAITSW;
					irq_ev[`DES_IRQ_TORQ_OFF] = 1'b1;
				end
			end
			S_COAST: begin
				if (standstill) begin
					state_next = err_reg ? S_FAULT : S_WAITSW;
					irq_ev[`DES_IRQ_TORQ_OFF] = 1'b1;
				end
			end
			S_FAULT: begin
				if (!err_reg) begin
					state_next = S_WAITSW;
				end
			end
			default: begin
				state_next = S_NOHW;
			end
		endcase
		if (err_ack && !irq_ev[`DES_IRQ_STOP_ERR]) begin
			err_next = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= S_NOHW;
			timer_reg  <= 16'h0000;
			err_reg    <= 1'b0;
			second_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			timer_reg  <= timer_next;
			err_reg    <= err_next;
			second_reg <= second_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs to power stage and controller
	// ------------------------------------------------------------------
	// Order: brake, torque, dc charge, phases, max current, job accept.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_reg   <= 6'h00;
			ax_code_reg <= `DES_AX_NOHW;
			cc_code_reg <= `DES_CC_NOHW;
		end else begin
			case (state_next)
				S_NOHW: begin
					drive_reg   <= 6'h00;
					ax_code_reg <= `DES_AX_NOHW;
					cc_code_reg <= `DES_CC_NOHW;
				end
				S_WAITSW: begin
					drive_reg   <= 6'h00;
					ax_code_reg <= `DES_AX_WAITSW;
					cc_code_reg <= `DES_CC_WAITSW;
				end
				S_RELEASE: begin
					drive_reg   <= 6'h0F;
					ax_code_reg <= `DES_AX_ACTIVE;
					cc_code_reg <= `DES_CC_RELEASE;
				end
				S_RUN: begin
					drive_reg   <= 6'h2F;
					ax_code_reg <= `DES_AX_ACTIVE;
					cc_code_reg <= `DES_CC_RUN;
				end
				S_RAMP: begin
					drive_reg   <= 6'h1F;
					ax_code_reg <= `DES_AX_STOPPING;
					cc_code_reg <= `DES_CC_STOPPING;
				end
				S_ENGAGE: begin
					drive_reg   <= 6'h1E;
					ax_code_reg <= `DES_AX_STOPPING;
					cc_code_reg <= `DES_CC_STOPPING;
				end
				S_COAST: begin
					drive_reg   <= 6'h01;
					ax_code_reg <= `DES_AX_STOPPING;
					cc_code_reg <= `DES_CC_STOPPING;
				end
				default: begin
					drive_reg   <= 6'h00;
					ax_code_reg <= `DES_AX_FAULT;
					cc_code_reg <= `DES_CC_FAULT;
				end
			endcase
		end
	end

	assign brake_relay_on        = drive_reg[0];
	assign torque_on             = drive_reg[1];
	assign dc_charge_on          = drive_reg[2];
	assign phases_connect        = drive_reg[3];
	assign max_current_decel     = drive_reg[4];
	assign job_accept            = drive_reg[5];
	assign axis_state_code       = ax_code_reg;
	assign controller_state_code = cc_code_reg;
	assign ready_contact         = !err_reg;

	// ------------------------------------------------------------------
	// Bus cycle tick
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_cnt_reg  <= 5'h00;
			cyc_tick_reg <= 1'b0;
		end else begin
			cyc_tick_reg <= 1'b0;
			if (tick) begin
				if (cyc_cnt_reg >= cycle_ticks(ctrl_reg[5:4]) - 5'h01) begin
					cyc_cnt_reg  <= 5'h00;
					cyc_tick_reg <= 1'b1;
				end else begin
					cyc_cnt_reg <= cyc_cnt_reg + 5'h01;
				end
			end
		end
	end

	assign bus_cycle_tick = cyc_tick_reg;

	// ------------------------------------------------------------------
	// APB registers
	// ------------------------------------------------------------------
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite && mapped(paddr);
	assign rd_access = psel && penable && !pwrite && mapped(paddr);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped(paddr);
	assign prdata    = prdata_reg;

	always @* begin
		rd_value = 32'h00000000;
		case (paddr)
			`DES_OFS_CTRL:     rd_value = {26'h0, ctrl_reg};
			`DES_OFS_STATUS:   rd_value = {state_reg, cc_code_reg,
				ax_code_reg, second_reg, err_reg, drive_reg};
			`DES_OFS_IRQ_STS:  rd_value = {28'h0, irq_sts_reg};
			`DES_OFS_IRQ_MASK: rd_value = {28'h0, irq_mask_reg};
			`DES_OFS_REL_DLY:  rd_value = {16'h0, rel_dly_reg};
			`DES_OFS_ENG_DLY:  rd_value = {16'h0, eng_dly_reg};
			`DES_OFS_DEADLINE: rd_value = {16'h0, deadline_reg};
			`DES_OFS_STANDSTL: rd_value = {16'h0, standstl_reg};
			default:           rd_value = 32'h00000000;
		endcase
		err_ack = wr_access && (paddr == `DES_OFS_ERR_CLR) && pwdata[0];
	end

	// Read data is captured in the setup cycle; the status clear on read
	// takes only the captured bits, so an event in between survives.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= 6'h00;
			rel_dly_reg  <= `DES_REL_DLY_TICKS;
			eng_dly_reg  <= `DES_ENG_DLY_TICKS;
			deadline_reg <= `DES_DEADLINE_TICKS;
			standstl_reg <= `DES_STANDSTILL_RPM;
			irq_mask_reg <= {`DES_IRQ_W{1'b0}};
			irq_sts_reg  <= {`DES_IRQ_W{1'b0}};
			rd_capt_reg  <= {`DES_IRQ_W{1'b0}};
			prdata_reg   <= 32'h00000000;
		end else begin
			if (setup) begin
				prdata_reg  <= rd_value;
				rd_capt_reg <= irq_sts_reg;
			end
			if (rd_access && paddr == `DES_OFS_IRQ_STS) begin
				irq_sts_reg <= (irq_sts_reg & ~rd_capt_reg) | irq_ev;
			end else begin
				irq_sts_reg <= irq_sts_reg | irq_ev;
			end
			if (wr_access) begin
				case (paddr)
					`DES_OFS_CTRL:     ctrl_reg <= pwdata[5:0];
					`DES_OFS_IRQ_MASK: irq_mask_reg <= pwdata[3:0];
					`DES_OFS_REL_DLY:  rel_dly_reg <= pwdata[15:0];
					`DES_OFS_ENG_DLY:  eng_dly_reg <= pwdata[15:0];
					`DES_OFS_DEADLINE: deadline_reg <= pwdata[15:0];
					`DES_OFS_STANDSTL: standstl_reg <= pwdata[15:0];
					default:           ctrl_reg <= ctrl_reg;
				endcase
			end
		end
	end

	assign irq = |(irq_sts_reg & irq_mask_reg);
endmodule

// [tb/des_power_stage_model.sv]
// Behavioural power stage and load that turn torque into measured speed.
`timescale 1ns/10ps
module des_power_stage_model (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// Drive commands
	input  wire        torque_on,
	input  wire        max_current_decel,
	input  wire [15:0] decel_step,
	// Speed feedback
	output logic [15:0] measured_speed
);
	// ------------------------------------------------------------------
	// Speed
	// ------------------------------------------------------------------
	// Speed falls by decel_step and clamps at zero, so it reaches zero and stays there until torque_on is set without max_current_decel.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			measured_speed <= 16'h0000;
		end else if (torque_on && !max_current_decel) begin
			if (measured_speed < 16'h03E8) begin
				measured_speed <= measured_speed + 16'h0032;
			end
		end else if (measured_speed > decel_step) begin
			measured_speed <= measured_speed - decel_step;
		end else begin
			measured_speed <= 16'h0000;
		end
	end
endmodule

// [tb/des_drive_enable_sequencer_monitor.sv]
// Checker of the sequencer's port behaviour, bound to the top module.
`timescale 1ns/10ps
`include "des_drive_enable_sequencer_map.vh"
module des_seq_monitor #(
	parameter TICK_CYCLES = 5000
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire [7:0]  paddr,
	input wire        pslverr,
	input wire        hw_enable_in,
	input wire [15:0] measured_speed,
	input wire [7:0]  axis_state_code,
	input wire [7:0]  controller_state_code,
	input wire        job_accept,
	input wire        brake_relay_on,
	input wire        torque_on,
	input wire        dc_charge_on,
	input wire        phases_connect,
	input wire        max_current_decel,
	input wire        ready_contact
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------------
	// Release timer
	// ------------------------------------------------------------------
	// Assumes release delays of at least three ticks are configured.
	logic [15:0] rel_cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_cnt_reg <= 16'h0000;
		end else if (!torque_on || max_current_decel) begin
			rel_cnt_reg <= 16'h0000;
		end else if (rel_cnt_reg != 16'hFFFF) begin
			rel_cnt_reg <= rel_cnt_reg + 16'h0001;
		end
	end
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	nohw_codes_a: assert property ((!hw_enable_in && !brake_relay_on &&
		!torque_on && ready_contact)[*6] |-> axis_state_code == 8'h00
		&& controller_state_code == 8'h03) else $error("bad idle codes");
	wait_codes_a: assert property ((hw_enable_in && !brake_relay_on &&
		!torque_on && ready_contact)[*6] |-> axis_state_code == 8'h01
		&& controller_state_code == 8'h10) else $error("bad wait codes");
	run_outputs_a: assert property (job_accept |-> brake_relay_on &&
		torque_on && dc_charge_on && phases_connect)
		else $error("jobs accepted without power");
	job_after_a: assert property ($rose(job_accept) |->
		rel_cnt_reg >= 2 * TICK_CYCLES) else $error("jobs accepted early");
	decel_max_a: assert property ($rose(max_current_decel) |-> torque_on
		&& !job_accept && axis_state_code == `DES_AX_STOPPING)
		else $error("bad ramp entry");
	brake_drop_a: assert property ($fell(brake_relay_on) &&
		max_current_decel && ready_contact |->
		$past(measured_speed) < 16'h000A) else $error("brake dropped fast");
	torque_hold_a: assert property ($fell(brake_relay_on) &&
		max_current_decel |-> torque_on[*8])
		else $error("torque removed early");
	ready_ramp_a: assert property ($fell(ready_contact) |->
		$past(max_current_decel)) else $error("ready opened outside ramp");
	bad_addr_a: assert property (psel && penable |->
		pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
		else $error("bad slave error");
endmodule
bind des_drive_enable_sequencer des_seq_monitor #(
	.TICK_CYCLES(TICK_CYCLES)
) u_des_seq_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pslverr(pslverr), .hw_enable_in(hw_enable_in),
	.measured_speed(measured_speed), .axis_state_code(axis_state_code),
	.controller_state_code(controller_state_code),
	.job_accept(job_accept), .brake_relay_on(brake_relay_on),
	.torque_on(torque_on), .dc_charge_on(dc_charge_on),
	.phases_connect(phases_connect),
	.max_current_decel(max_current_decel), .ready_contact(ready_contact)
);

// [tb/des_drive_enable_sequencer_bench.sv]
// Self-checking testbench of the drive enable sequencer.
`timescale 1ns/10ps
`include "des_drive_enable_sequencer_map.vh"
module des_drive_enable_sequencer_bench;
	localparam TK = 10;
	logic        pclk, presetn, psel, penable, pwrite, hw_enable_in, bad;
	logic [7:0]  paddr;
	logic [31:0] pwdata, q;
	logic [15:0] decel_step;
	wire  [31:0] prdata;
	wire  [15:0] measured_speed;
	wire  [7:0]  axis_state_code, controller_state_code;
	wire         pready, pslverr, job_accept, bus_cycle_tick, irq;
	wire         brake_relay_on, torque_on, dc_charge_on, phases_connect;
	wire         max_current_decel, ready_contact;
	wire  [4:0]  mon = {bus_cycle_tick, ready_contact, torque_on,
		brake_relay_on, job_accept};
	wire  [15:0] codes = {axis_state_code, controller_state_code};
	integer      err_count, tests_run, n, i;
	des_drive_enable_sequencer #(.TICK_CYCLES(TK)) u_des_drive_enable_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_enable_in(hw_enable_in),
		.axis_state_code(axis_state_code),
		.controller_state_code(controller_state_code),
		.job_accept(job_accept), .bus_cycle_tick(bus_cycle_tick), .irq(irq),
		.measured_speed(measured_speed), .brake_relay_on(brake_relay_on),
		.torque_on(torque_on), .dc_charge_on(dc_charge_on),
		.phases_connect(phases_connect),
		.max_current_decel(max_current_decel), .ready_contact(ready_contact));
	des_power_stage_model u_des_power_stage_model (
		.pclk(pclk), .presetn(presetn), .torque_on(torque_on),
		.max_current_decel(max_current_decel), .decel_step(decel_step),
		.measured_speed(measured_speed));
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer k;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k = k + 1;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		bad = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wait_on(input integer s, input logic v, output integer c);
		c = 0;
		while (mon[s] !== v && c < 3000) begin
			@(posedge pclk);
			c = c + 1;
		end
	endtask
	task idle(input integer c);
		repeat (c) @(posedge pclk);
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_regs;
		logic [7:0]  ra [7];
		logic [31:0] rv [7];
		ra = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24};
		rv = '{32'h0, 32'h0, 32'h190, 32'hC8, 32'hFA0, 32'hA, 32'h0};
		for (i = 0; i < 7; i = i + 1) begin
			apb(1'b0, ra[i], 32'h0);
			check(q, rv[i]);
			check(bad, i == 6);
		end
		$display("test regs done");
	endtask
	task t_codes;
		check(codes, 16'h0003);
		hw_enable_in <= 1'b1;
		idle(6);
		check(codes, 16'h0110);
		$display("test codes done");
	endtask
	task t_enable;
		apb(1'b1, `DES_OFS_REL_DLY, 32'h4);
		apb(1'b1, `DES_OFS_ENG_DLY, 32'h4);
		apb(1'b1, `DES_OFS_IRQ_MASK, 32'h1);
		apb(1'b1, `DES_OFS_CTRL, 32'h1);
		idle(3);
		check({brake_relay_on, torque_on, dc_charge_on, phases_connect,
			job_accept}, 5'b11110);
		wait_on(0, 1'b1, n);
		check(n >= 3 * TK && n <= 5 * TK + 4, 1'b1);
		idle(2);
		check(irq, 1'b1);
		apb(1'b0, `DES_OFS_IRQ_STS, 32'h0);
		check(q[0], 1'b1);
		idle(1);
		check(irq, 1'b0);
		$display("test enable done");
	endtask
	task t_stop;
		decel_step <= 16'h0032;
		apb(1'b1, `DES_OFS_IRQ_MASK, 32'h0);
		apb(1'b1, `DES_OFS_CTRL, 32'h0);
		idle(3);
		check({max_current_decel, torque_on, ready_contact}, 3'b111);
		wait_on(1, 1'b0, n);
		check(measured_speed < 16'h000A, 1'b1);
		wait_on(2, 1'b0, n);
		check(n >= 3 * TK && n <= 5 * TK + 4, 1'b1);
		check(ready_contact, 1'b1);
		idle(3);
		check(codes, 16'h0110);
		apb(1'b0, `DES_OFS_IRQ_STS, 32'h0);
		check(q[3:1], 3'b011);
		$display("test stop done");
	endtask
	task t_abort;
		apb(1'b1, `DES_OFS_CTRL, 32'h1);
		idle(5);
		apb(1'b1, `DES_OFS_CTRL, 32'h0);
		idle(4);
		check({max_current_decel, torque_on, job_accept}, 3'b110);
		wait_on(2, 1'b0, n);
		check(n < 3000, 1'b1);
		$display("test abort done");
	endtask
	task t_coast;
		apb(1'b1, `DES_OFS_CTRL, 32'h3);
		wait_on(0, 1'b1, n);
		apb(1'b1, `DES_OFS_CTRL, 32'h2);
		idle(4);
		check({max_current_decel, torque_on, brake_relay_on}, 3'b001);
		wait_on(1, 1'b0, n);
		check(n < 3000, 1'b1);
		apb(1'b1, `DES_OFS_CTRL, 32'h0);
		$display("test coast done");
	endtask
	task t_deadline;
		decel_step <= 16'h0001;
		apb(1'b1, `DES_OFS_DEADLINE, 32'h5);
		apb(1'b1, `DES_OFS_CTRL, 32'h1);
		wait_on(0, 1'b1, n);
		apb(1'b1, `DES_OFS_CTRL, 32'h0);
		wait_on(3, 1'b0, n);
		check(n >= 4 * TK && n <= 6 * TK + 4, 1'b1);
		check(irq, 1'b0);
		apb(1'b0, `DES_OFS_IRQ_STS, 32'h0);
		check(q[3], 1'b1);
		wait_on(2, 1'b0, n);
		idle(3);
		check(codes, {`DES_AX_FAULT, `DES_CC_FAULT});
		apb(1'b1, `DES_OFS_ERR_CLR, 32'h1);
		idle(4);
		check({ready_contact, codes}, 17'h10110);
		$display("test deadline done");
	endtask
	// Missed deadline with coast on error: torque off, brake relay kept on (brake lifted).
	task t_coast_err;
		apb(1'b1, `DES_OFS_CTRL, 32'h5);
		wait_on(0, 1'b1, n);
		apb(1'b1, `DES_OFS_CTRL, 32'h4);
		wait_on(3, 1'b0, n);
		idle(2);
		check({max_current_decel, torque_on, brake_relay_on}, 3'b001);
		wait_on(1, 1'b0, n);
		idle(2);
		check(codes, {`DES_AX_FAULT, `DES_CC_FAULT});
		apb(1'b1, `DES_OFS_ERR_CLR, 32'h1);
		apb(1'b1, `DES_OFS_CTRL, 32'h0);
		idle(4);
		check({ready_contact, codes}, 17'h10110);
		$display("test coast error done");
	endtask
	task t_tick;
		for (i = 0; i < 3; i = i + 1) begin
			apb(1'b1, `DES_OFS_CTRL, i << 4);
			wait_on(4, 1'b1, n);
			idle(1);
			wait_on(4, 1'b1, n);
			idle(1);
			wait_on(4, 1'b1, n);
			check(n + 1, (4 << i) * TK);
		end
		$display("test tick done");
	endtask
	// ------------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; hw_enable_in = 1'b0;
		decel_step = 16'h0032; err_count = 0; tests_run = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_codes;
		t_enable;
		t_stop;
		t_abort;
		t_coast;
		t_deadline;
		t_coast_err;
		t_tick;
		results;
	end
	initial begin
		#(40000 * 50);
		err_count = err_count + 1;
		results;
	end
endmodule
